/* File: hw/pcs_flow.sv */
/*
 Program counter, page latch, return stack and indirect data addressing,
 with an APB slave for the software-visible registers.
 Assumes the decoder presents one flow operation per instruction on the
 same clock, and a data memory that returns read data one cycle after
 its read strobe is registered (on the edge that samples it).
*/
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pcs_flow
    import pcs_pkg::*;
(
    input wire logic sys_clk_i,                       // System clock
    input wire logic rst_i,                           // Async reset, high
    input wire logic psel_i,                          // APB select
    input wire logic penable_i,                       // APB enable
    input wire logic pwrite_i,                        // APB direction
    input wire logic [`PCS_APB_AW-1:0] paddr_i,       // APB byte address
    input wire logic [`PCS_APB_DW-1:0] pwdata_i,      // APB write data
    output logic [`PCS_APB_DW-1:0] prdata_o,          // APB read data
    output logic pready_o,                            // APB ready
    output logic pslverr_o,                           // APB error
    input wire logic op_valid_i,                      // Instruction executes
    input wire pcs_op_t op_i,                         // Flow operation
    input wire logic [`PCS_TGT_W-1:0] target_i,       // Branch target
    input wire logic [`PCS_BYTE_W-1:0] dmem_rdata_i,  // Data memory read
    output logic [`PCS_PC_W-1:0] pc_o,                // Fetch address
    output logic [`PCS_IND_W-1:0] ind_addr_o,         // Indirect address
    output logic [`PCS_IND_W-1:0] dmem_addr_o,        // Data memory address
    output logic dmem_re_o,                           // Data memory read
    output logic dmem_we_o,                           // Data memory write
    output logic [`PCS_BYTE_W-1:0] dmem_wdata_o       // Data memory data
);

    ////////////////////////////////////////////////////////////////////
    // Program flow state
    logic [`PCS_PC_W-1:0] pc_r;          // Program counter
    logic [`PCS_PC_W-1:0] pc_nxt;
    logic [`PCS_PC_W-1:0] pc_inc;        // Address of next instruction
    logic [`PCS_LATCH_W-1:0] latch_r;    // Page and high-byte latch
    logic [`PCS_LATCH_W-1:0] latch_nxt;
    logic push;                          // Stack push this cycle
    logic pop;                           // Stack pop this cycle
    logic [`PCS_PC_W-1:0] push_data;     // Value pushed
    logic [`PCS_PC_W-1:0] stack_top;     // Value a pop returns

    // Indirect addressing state
    logic [`PCS_BYTE_W-1:0] fsr_r;       // File select pointer
    logic [`PCS_BYTE_W-1:0] fsr_nxt;
    logic bank_r;                        // Indirect bank bit
    logic bank_nxt;
    logic [`PCS_IND_W-1:0] ind_addr;     // Bank bit over pointer
    logic fsr_self;                      // Pointer selects the port itself

    // Bus slave state
    pcs_bus_st_t st_r;                   // Slave phase
    pcs_bus_st_t st_nxt;
    logic pready_r;                      // Ready to master
    logic pready_nxt;
    logic pslverr_r;                     // Error to master
    logic pslverr_nxt;
    logic [`PCS_APB_DW-1:0] prdata_r;    // Read data to master
    logic [`PCS_APB_DW-1:0] prdata_nxt;
    logic dre_r;                         // Memory read strobe
    logic dre_nxt;
    logic dwe_r;                         // Memory write strobe
    logic dwe_nxt;
    logic [`PCS_IND_W-1:0] daddr_r;      // Memory address
    logic [`PCS_IND_W-1:0] daddr_nxt;
    logic [`PCS_BYTE_W-1:0] dwdata_r;    // Memory write data
    logic [`PCS_BYTE_W-1:0] dwdata_nxt;

    // Decode helpers
    logic access;                        // Access phase in progress
    logic wr_commit;                     // Write takes effect this edge
    logic hit_pcl;
    logic hit_latch;
    logic hit_fsr;
    logic hit_status;
    logic hit_indirect_data_port;
    logic mapped;                        // Address is a known register
    logic [`PCS_APB_DW-1:0] reg_rd;      // Read value of a register

    ////////////////////////////////////////////////////////////////////
    // Address decode and indirect address
    assign access = psel_i && penable_i;
    assign wr_commit = (st_r == PCS_BUS_DONE) && pwrite_i;
    assign hit_pcl = (paddr_i == `PCS_OFF_PCL);
    assign hit_latch = (paddr_i == `PCS_OFF_LATCH);
    assign hit_fsr = (paddr_i == `PCS_OFF_FSR);
    assign hit_status = (paddr_i == `PCS_OFF_STATUS);
    assign hit_indirect_data_port = (paddr_i == `PCS_OFF_INDIRECT_DATA_PORT);
    assign mapped = hit_pcl || hit_latch || hit_fsr || hit_status
                    || hit_indirect_data_port;
    // Bank bit sits above the 8-bit pointer
    assign ind_addr = {bank_r, fsr_r};
    assign fsr_self = (fsr_r == `PCS_FSR_SELF);

    ////////////////////////////////////////////////////////////////////
    // Register read mux
    always_comb begin
        reg_rd = '0;
        if (hit_pcl) begin
            // Only the low byte of the PC is visible
            reg_rd = `PCS_APB_DW'(pc_r[`PCS_PCL_W-1:0]);
        end else if (hit_latch) begin
            reg_rd = `PCS_APB_DW'(latch_r);
        end else if (hit_fsr) begin
            reg_rd = `PCS_APB_DW'(fsr_r);
        end else if (hit_status) begin
            reg_rd[`PCS_BANK_BIT] = bank_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus slave sequencing and indirect memory strobes
    always_comb begin
        st_nxt = st_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        dre_nxt = 1'b0;
        dwe_nxt = 1'b0;
        daddr_nxt = daddr_r;
        dwdata_nxt = dwdata_r;
        unique case (st_r)
            PCS_BUS_IDLE: begin
                if (access) begin
                    if (hit_indirect_data_port && !pwrite_i && !fsr_self) begin
                        // Port has no storage: read the pointed byte
                        dre_nxt = 1'b1;
                        daddr_nxt = ind_addr;
                        st_nxt = PCS_BUS_RD1;
                    end else begin
                        // Port reading itself gives zero
                        prdata_nxt = (pwrite_i || hit_indirect_data_port) ? '0 : reg_rd;
                        pslverr_nxt = !mapped;
                        pready_nxt = 1'b1;
                        st_nxt = PCS_BUS_DONE;
                    end
                end
            end
            PCS_BUS_RD1: begin
                // Memory samples the strobe during this cycle
                st_nxt = PCS_BUS_RD2;
            end
            PCS_BUS_RD2: begin
                prdata_nxt = `PCS_APB_DW'(dmem_rdata_i);
                pready_nxt = 1'b1;
                st_nxt = PCS_BUS_DONE;
            end
            PCS_BUS_DONE: begin
                st_nxt = PCS_BUS_IDLE;
                // Indirect write goes to the pointed byte
                // and is dropped when the port points at itself
                if (wr_commit && hit_indirect_data_port && !fsr_self) begin
                    dwe_nxt = 1'b1;
                    daddr_nxt = ind_addr;
                    dwdata_nxt = pwdata_i[`PCS_BYTE_W-1:0];
                end
            end
        endcase
    end

    // Bus slave registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= PCS_BUS_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
            dre_r <= 1'b0;
            dwe_r <= 1'b0;
            daddr_r <= '0;
            dwdata_r <= '0;
        end else begin
            st_r <= st_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
            dre_r <= dre_nxt;
            dwe_r <= dwe_nxt;
            daddr_r <= daddr_nxt;
            dwdata_r <= dwdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Software register writes
    always_comb begin
        latch_nxt = latch_r;
        fsr_nxt = fsr_r;
        bank_nxt = bank_r;
        if (wr_commit && hit_latch) begin
            // Latch changes only by software, never by the stack
            latch_nxt = pwdata_i[`PCS_LATCH_W-1:0];
        end
        if (wr_commit && hit_fsr) begin
            fsr_nxt = pwdata_i[`PCS_BYTE_W-1:0];
        end
        if (wr_commit && hit_status) begin
            bank_nxt = pwdata_i[`PCS_BANK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Program counter and stack control
    always_comb begin
        pc_inc = pc_r + `PCS_PC_STEP;
        pc_nxt = pc_r;
        push = 1'b0;
        pop = 1'b0;
        push_data = pc_inc;
        if (wr_commit && hit_pcl) begin
            // Low-byte write pulls the upper bits from the latch
            pc_nxt = {latch_r, pwdata_i[`PCS_PCL_W-1:0]};
        end else if (op_valid_i) begin
            unique case (op_i)
                PCS_OP_STEP: begin
                    pc_nxt = pc_inc;
                end
                PCS_OP_CALL: begin
                    // Return address is the next instruction
                    push = 1'b1;
                    push_data = pc_inc;
                    // Page from latch, offset from the word
                    pc_nxt = {latch_r[`PCS_LATCH_PAGE_MSB:`PCS_LATCH_PAGE_LSB],
                              target_i};
                end
                PCS_OP_JUMP: begin
                    // Same paging as a call, nothing pushed
                    pc_nxt = {latch_r[`PCS_LATCH_PAGE_MSB:`PCS_LATCH_PAGE_LSB],
                              target_i};
                end
                PCS_OP_RET, PCS_OP_RETLIT, PCS_OP_RETINT: begin
                    // Whole 13-bit PC comes back from the stack
                    pop = 1'b1;
                    pc_nxt = stack_top;
                end
                PCS_OP_VECTOR: begin
                    // Interrupted instruction has not run; resume at it
                    push = 1'b1;
                    push_data = pc_r;
                    pc_nxt = `PCS_INT_VECTOR;
                end
                default: begin
                    // Unknown operation behaves as a no-operation
                    pc_nxt = pc_inc;
                end
            endcase
        end
    end

    // Return stack
    pcs_ret_stack u_stack (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .push_i(push),
        .pop_i(pop),
        .push_data_i(push_data),
        .top_o(stack_top)
    );

    // Flow and pointer registers; every reset clears the PC
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_r <= `PCS_PC_RST;
            latch_r <= `PCS_LATCH_RST;
            fsr_r <= `PCS_FSR_RST;
            bank_r <= 1'b0;
        end else begin
            pc_r <= pc_nxt;
            latch_r <= latch_nxt;
            fsr_r <= fsr_nxt;
            bank_r <= bank_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign pc_o = pc_r;
    assign ind_addr_o = ind_addr;
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign dmem_addr_o = daddr_r;
    assign dmem_re_o = dre_r;
    assign dmem_we_o = dwe_r;
    assign dmem_wdata_o = dwdata_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    reset_clear_a: assert property (
        $fell(rst_i) |-> pc_r == `PCS_PC_RST)
        else $error("PC not cleared by reset");

    pcl_read_a: assert property (
        (st_r == PCS_BUS_IDLE) && access && hit_pcl && !pwrite_i
        |=> prdata_o == `PCS_APB_DW'($past(pc_r[`PCS_PCL_W-1:0])))
        else $error("low byte read mismatch");

    pcl_write_a: assert property (
        wr_commit && hit_pcl
        |=> pc_r == {$past(latch_r), $past(pwdata_i[`PCS_PCL_W-1:0])})
        else $error("low byte write did not load PC from latch");

    call_target_a: assert property (
        op_valid_i && (op_i == PCS_OP_CALL) && !(wr_commit && hit_pcl)
        |=> pc_r[`PCS_TGT_W-1:0] == $past(target_i)
            && pc_r[`PCS_PC_W-1:`PCS_TGT_W]
               == $past(latch_r[`PCS_LATCH_PAGE_MSB:`PCS_LATCH_PAGE_LSB]))
        else $error("call target mispaged");

    call_return_a: assert property (
        op_valid_i && (op_i == PCS_OP_CALL) && !(wr_commit && hit_pcl)
        |=> stack_top == $past(pc_r) + `PCS_PC_STEP)
        else $error("call pushed wrong return address");

    ret_reload_a: assert property (
        pop |=> pc_r == $past(stack_top))
        else $error("return did not reload PC");

    latch_keep_a: assert property (
        (push || pop) && !(wr_commit && hit_latch) |=> $stable(latch_r))
        else $error("stack action changed latch");

    nop_step_a: assert property (
        op_valid_i && !(op_i inside {PCS_OP_CALL, PCS_OP_JUMP, PCS_OP_RET,
            PCS_OP_RETLIT, PCS_OP_RETINT, PCS_OP_VECTOR})
        && !(wr_commit && hit_pcl) |=> pc_r == $past(pc_r) + `PCS_PC_STEP)
        else $error("invalid operation did not step PC");

    self_read_a: assert property (
        (st_r == PCS_BUS_IDLE) && access && hit_indirect_data_port && fsr_self
        |=> prdata_o == '0 && pready_o)
        else $error("self-pointed read not zero");

    self_write_a: assert property (
        wr_commit && hit_indirect_data_port && fsr_self |=> !dmem_we_o)
        else $error("self-pointed write stored data");

    ind_read_a: assert property (
        (st_r == PCS_BUS_IDLE) && access && hit_indirect_data_port && !pwrite_i
        && !fsr_self |=> dmem_re_o && dmem_addr_o == $past(ind_addr)
        ##2 pready_o)
        else $error("indirect read not issued to pointed address");

    call_cover_c: cover property (
        op_valid_i && (op_i == PCS_OP_CALL) ##[1:20] pop);
    vector_cover_c: cover property (op_valid_i && (op_i == PCS_OP_VECTOR));
    ind_read_cover_c: cover property (dmem_re_o ##2 pready_o);
    ind_write_cover_c: cover property (dmem_we_o);

endmodule

/* File: shared/pcs_defines.svh */
/*
 Constants of the program-flow and indirect-addressing block: widths,
 register offsets, field positions, reset values and the vector address.
 Assumes it is included by bare name; the guard allows repeated inclusion.
*/
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// Widths
`define PCS_PC_W 13
`define PCS_PCL_W 8
`define PCS_TGT_W 11
`define PCS_LATCH_W 5
`define PCS_SP_W 3
`define PCS_DEPTH 8
`define PCS_IND_W 9
`define PCS_BYTE_W 8
`define PCS_APB_AW 12
`define PCS_APB_DW 32

// Field positions
`define PCS_LATCH_PAGE_MSB 4
`define PCS_LATCH_PAGE_LSB 3
`define PCS_BANK_BIT 7

// Register byte offsets on the bus
`define PCS_OFF_PCL 12'h000
`define PCS_OFF_LATCH 12'h004
`define PCS_OFF_FSR 12'h008
`define PCS_OFF_STATUS 12'h00c
`define PCS_OFF_INDIRECT_DATA_PORT 12'h010

// Reset values and fixed values
`define PCS_PC_RST 13'h0000
`define PCS_PC_STEP 13'h0001
`define PCS_LATCH_RST 5'h00
`define PCS_FSR_RST 8'h00
`define PCS_FSR_SELF 8'h00
`define PCS_INT_VECTOR 13'h0004
`define PCS_SP_STEP 3'h1

`endif

/* File: shared/pcs_pkg.sv */
/*
 Types of the program-flow block: flow operations from the decoder and
 the states of the register bus slave.
 Assumes the constants header is on the include path.
*/
`include "pcs_defines.svh"

package pcs_pkg;

    // Flow operation presented by the decoder with each instruction
    typedef enum logic [2:0] {
        PCS_OP_STEP = 3'b000,
        PCS_OP_CALL = 3'b001,
        PCS_OP_JUMP = 3'b010,
        PCS_OP_RET = 3'b011,
        PCS_OP_RETLIT = 3'b100,
        PCS_OP_RETINT = 3'b101,
        PCS_OP_VECTOR = 3'b110
    } pcs_op_t;

    // Bus slave states
    typedef enum logic [1:0] {
        PCS_BUS_IDLE = 2'b00,
        PCS_BUS_RD1 = 2'b01,
        PCS_BUS_RD2 = 2'b10,
        PCS_BUS_DONE = 2'b11
    } pcs_bus_st_t;

endpackage

/* File: hw/pcs_ret_stack.sv */
/*
 Circular return stack of eight 13-bit entries with a hidden pointer.
 Assumes push and pop never arrive in the same cycle.
*/
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pcs_ret_stack
    import pcs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [`PCS_PC_W-1:0] push_data_i,
    output logic [`PCS_PC_W-1:0] top_o
);

    ////////////////////////////////////////////////////////////////////
    // State
    logic [`PCS_PC_W-1:0] mem_r [`PCS_DEPTH];   // Entries, no reset
    logic [`PCS_SP_W-1:0] sp_r;                 // Next free slot
    logic [`PCS_SP_W-1:0] sp_nxt;
    logic [`PCS_SP_W-1:0] sp_top;               // Most recent entry

    ////////////////////////////////////////////////////////////////////
    // Pointer moves; the 3-bit count wraps with no flag
    // Nothing reports overflow or underflow
    always_comb begin
        sp_top = sp_r - `PCS_SP_STEP;
        sp_nxt = sp_r;
        if (push_i) begin
            sp_nxt = sp_r + `PCS_SP_STEP;
        end else if (pop_i) begin
            sp_nxt = sp_top;
        end
    end

    // Top entry is read ahead of the pop
    assign top_o = mem_r[sp_top];

    // Pointer register, hidden from software
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sp_r <= '0;
        end else begin
            sp_r <= sp_nxt;
        end
    end

    // One entry per slot; a push overwrites the oldest on wrap
    genvar gi;
    generate
        for (gi = 0; gi < `PCS_DEPTH; gi++) begin : g_slot
            always_ff @(posedge sys_clk_i) begin
                if (push_i && (sp_r == `PCS_SP_W'(gi))) begin
                    mem_r[gi] <= push_data_i;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Checks
    wrap_ptr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        push_i |=> sp_r == $past(sp_r) + `PCS_SP_STEP)
        else $error("stack pointer did not advance on push");

    push_pop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        push_i ##1 pop_i |-> top_o == $past(push_data_i))
        else $error("pop did not return the last pushed value");

    wrap_cover_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        push_i && (sp_r == '1));

endmodule

/* File: hw/pcs_dummy_unused.sv */
`timescale 1ns/1ps

/* File: tb/pcs_dmem_model.sv */
/*
 Data memory model that sits on the far side of the indirect port.
 Assumes a synchronous RAM: read data is valid in the cycle after the
 strobe.
*/
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pcs_dmem_model (
    input wire logic sys_clk_i,
    input wire logic [`PCS_IND_W-1:0] addr_i,
    input wire logic re_i,
    input wire logic we_i,
    input wire logic [`PCS_BYTE_W-1:0] wdata_i,
    output logic [`PCS_BYTE_W-1:0] rdata_o,
    output int wr_cnt_o
);
    logic [`PCS_BYTE_W-1:0] mem_r [0:511]; // Byte storage
    ////////////////////////////////////////////////////////////////////
    // Start from a known value on the read bus
    initial begin
        rdata_o = 8'h00;
        wr_cnt_o = 0;
    end
    // Writes, write count, and reads one cycle behind the strobe
    always @(posedge sys_clk_i) begin
        if (we_i) begin
            mem_r[addr_i] <= wdata_i;
            wr_cnt_o <= wr_cnt_o + 1;
        end
        if (re_i) begin
            rdata_o <= mem_r[addr_i];
        end else begin
            rdata_o <= ~rdata_o; // Not valid: keep the bus changing
        end
    end
endmodule

/* File: tb/pc_stack_indirect_addressing_tb_top.sv */
/*
 Self-checking bench for the program-flow block: APB registers, flow
 operations, return stack and indirect access to a data memory model.
 Assumes the constants header is on the include path.
*/
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pc_stack_indirect_addressing_tb_top
    import pcs_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, opv = 1'b0, op_d = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, dre, dwe;
    pcs_op_t op = PCS_OP_STEP;
    logic [10:0] tgt = 11'h000;
    logic [7:0] mrd, dwd;
    logic [12:0] pc_w, pc;
    logic [12:0] stk [0:7]; // Expected stack contents
    logic [8:0] ind, daddr;
    logic [4:0] lat; // Expected latch
    logic [2:0] sp; // Expected stack pointer
    logic b2b = 1'b0; // Next op follows with no idle cycle
    logic [32:0] rd_q [$]; // Expected {error, read data}
    logic [12:0] pc_q [$]; // Expected pc after each op
    int err_total = 0, checks = 0, wcnt, wc0;

    always #10 clk = ~clk;

    pcs_flow u_pcs_flow (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .op_valid_i(opv), .op_i(op), .target_i(tgt),
        .dmem_rdata_i(mrd), .pc_o(pc_w), .ind_addr_o(ind),
        .dmem_addr_o(daddr), .dmem_re_o(dre), .dmem_we_o(dwe),
        .dmem_wdata_o(dwd));
    pcs_dmem_model u_pcs_dmem_model (.sys_clk_i(clk), .addr_i(daddr),
        .re_i(dre), .we_i(dwe), .wdata_i(dwd), .rdata_o(mrd),
        .wr_cnt_o(wcnt));
    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task check(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Report and end the run
    task conclude;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            conclude();
        end else begin
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    // Read with its expected answer noted first
    task rd(input logic [11:0] a, input logic [32:0] exp);
        rd_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    // One flow operation; expected pc worked out beforehand
    task op_t(input pcs_op_t o, input logic [10:0] t);
        case (o)
            PCS_OP_CALL: begin
                stk[sp] = pc + 13'h1;
                sp++;
                pc = {lat[4:3], t};
            end
            PCS_OP_JUMP: pc = {lat[4:3], t};
            PCS_OP_VECTOR: begin
                stk[sp] = pc;
                sp++;
                pc = `PCS_INT_VECTOR;
            end
            PCS_OP_RET, PCS_OP_RETLIT, PCS_OP_RETINT: begin
                sp--;
                pc = stk[sp];
            end
            default: pc = pc + 13'h1;
        endcase
        pc_q.push_back(pc);
        @(posedge clk);
        opv <= 1'b1;
        op <= o;
        tgt <= t;
        // Chained ops leave opv up for the next call to reuse
        if (!b2b) begin
            @(posedge clk);
            opv <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    // Watcher: compare each result with the oldest note
    always @(posedge clk) op_d <= opv;
    always @(negedge clk) begin
        if (op_d) begin
            check({20'h0, pc_w}, {20'h0, pc_q.pop_front()});
        end
        if (pready && !pwr) begin
            check({pslverr, prdata}, rd_q.size() ? rd_q.pop_front()
                : {33{1'bx}});
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(65));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        sp = 3'h0;
        pc = 13'h0;
        rd(`PCS_OFF_PCL, 33'h0);
        wr_lat(5'h1f);
        apb(1'b1, `PCS_OFF_PCL, 32'ha5);
        pc = 13'h1fa5;
        rd(`PCS_OFF_PCL, 33'h0a5);
        op_t(PCS_OP_STEP, 11'h0);
        op_t(pcs_op_t'(3'b111), 11'h0);
        wr_lat(5'h18);
        op_t(PCS_OP_JUMP, 11'($urandom()));
        op_t(PCS_OP_VECTOR, 11'h0);
        repeat (9) op_t(PCS_OP_CALL, 11'($urandom()));
        for (int i = 0; i < 10; i++) begin
            op_t(pcs_op_t'(3'd3 + 3'(i % 3)), 11'h0);
        end
        // Call then return on consecutive cycles
        b2b = 1'b1;
        op_t(PCS_OP_CALL, 11'($urandom()));
        b2b = 1'b0;
        op_t(PCS_OP_RET, 11'h0);
        rd(`PCS_OFF_LATCH, 33'h018);
        apb(1'b1, `PCS_OFF_FSR, 32'h34);
        apb(1'b1, `PCS_OFF_STATUS, 32'h80);
        // Let the bank bit settle after the committing edge
        @(negedge clk);
        check({24'h0, ind}, 33'h134);
        apb(1'b1, `PCS_OFF_INDIRECT_DATA_PORT, 32'h5a);
        rd(`PCS_OFF_INDIRECT_DATA_PORT, 33'h05a);
        rd(`PCS_OFF_STATUS, 33'h080);
        apb(1'b1, `PCS_OFF_FSR, 32'h0);
        wc0 = wcnt;
        apb(1'b1, `PCS_OFF_INDIRECT_DATA_PORT, 32'h77);
        repeat (3) @(posedge clk);
        check(33'(wcnt - wc0), 33'h0);
        rd(`PCS_OFF_INDIRECT_DATA_PORT, 33'h0);
        rd(12'h014, 33'h100000000);
        rd(12'h002, 33'h100000000);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        pc = 13'h0;
        sp = 3'h0;
        lat = 5'h0;
        op_t(PCS_OP_STEP, 11'h0);
        repeat (4) @(posedge clk);
        conclude();
    end
    // Latch write, mirrored in the expected latch
    task wr_lat(input logic [4:0] v);
        apb(1'b1, `PCS_OFF_LATCH, {27'h0, v});
        lat = v;
    endtask
endmodule
